// File: hw/timer_source_and_stop_control.sv
// Purpose: count source selection and run/stop for six 8-bit timers
// Assumes: counters and overflow generation live outside this block
// Notes: count enables are one-cycle pulses, gated by the halt bits
`timescale 1ns/100ps

module timer_source_and_stop_control
    import timer_src_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic main_osc,
    input wire logic sub_osc,
    input wire logic external_count_pin,
    input wire logic [5:0] timer_overflow,
    output logic [5:0] count_pulse,
    output logic [5:0] timer_halted
);
    // ==========================================================
    // pin synchronisers
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] next_sync_a;
    logic [2:0] next_sync_b;
    logic main_s;
    logic sub_s;
    logic ext_s;

    always_comb begin
        next_sync_a = {external_count_pin, sub_osc, main_osc};
        next_sync_b = sync_a;
        main_s = sync_b[0];
        sub_s = sync_b[1];
        ext_s = sync_b[2];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    // ==========================================================
    // registers
    logic [7:0] mode_first;
    logic [7:0] mode_second;
    logic [1:0] sys_ctrl;
    logic [7:0] next_mode_first;
    logic [7:0] next_mode_second;
    logic [1:0] next_sys_ctrl;

    // ==========================================================
    // axi4-lite slave
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    logic next_aw_held;
    logic next_w_held;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [7:0] next_w_byte;
    logic next_w_lane;
    logic [1:0] next_bresp;
    logic next_bvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_rvalid;
    logic [31:0] status_word;

    // each register owns one word at four times its index
    function automatic logic [1:0] decode(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] w;
        w = {a[ADDR_W-1:2], 2'b00};
        if (w == ADDR_MODE_FIRST_BYTE) begin
            decode = 2'd1;
        end else if (w == ADDR_MODE_SECOND_BYTE) begin
            decode = 2'd2;
        end else if (w == ADDR_SYS_CTRL) begin
            decode = 2'd3;
        end else begin
            decode = 2'd0;
        end
    endfunction

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_byte = w_byte;
        next_w_lane = w_lane;
        next_bresp = s_axi_bresp;
        next_bvalid = s_axi_bvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_rvalid = s_axi_rvalid;
        next_mode_first = mode_first;
        next_mode_second = mode_second;
        next_sys_ctrl = sys_ctrl;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_byte = s_axi_wdata[7:0];
            next_w_lane = s_axi_wstrb[0];
        end
        if (next_aw_held && next_w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            unique case (decode(next_aw_addr))
                2'd1: if (next_w_lane) next_mode_first = next_w_byte;
                2'd2: if (next_w_lane) next_mode_second = next_w_byte;
                2'd3: if (next_w_lane) next_sys_ctrl = next_w_byte[1:0];
                2'd0: next_bresp = RESP_SLVERR;
            endcase
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = '0;
            if (s_axi_araddr[ADDR_W-1:2] == ADDR_STATUS[ADDR_W-1:2]) begin
                next_rdata = status_word;
            end else begin
                unique case (decode(s_axi_araddr))
                    2'd1: next_rdata = {24'h000000, mode_first};
                    2'd2: next_rdata = {24'h000000, mode_second};
                    2'd3: next_rdata = {30'h0000000, sys_ctrl};
                    2'd0: next_rresp = RESP_SLVERR;
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_bvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            mode_first <= MODE_FIRST_RESET;
            mode_second <= MODE_SECOND_RESET;
            sys_ctrl <= SYS_CTRL_RESET;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_byte <= next_w_byte;
            w_lane <= next_w_lane;
            s_axi_bresp <= next_bresp;
            s_axi_bvalid <= next_bvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            s_axi_rvalid <= next_rvalid;
            mode_first <= next_mode_first;
            mode_second <= next_mode_second;
            sys_ctrl <= next_sys_ctrl;
        end
    end

    // ==========================================================
    // prescaler on the system oscillator
    logic sys_osc;
    logic sys_edge;
    logic sub_prev;
    logic next_sub_prev;
    logic sub_edge;
    logic ext_prev;
    logic next_ext_prev;
    logic ext_edge;
    logic [DIV_W-1:0] tick;

    assign sys_osc = sys_ctrl[F_SYS_SUB] ? sub_s : main_s;

    osc_prescaler u_osc_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .osc_level(sys_osc),
        .osc_edge(sys_edge),
        .tick(tick)
    );

    always_comb begin
        next_sub_prev = sub_s;
        next_ext_prev = ext_s;
        sub_edge = sub_s & ~sub_prev;
        ext_edge = ext_s & ~ext_prev;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sub_prev <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            sub_prev <= next_sub_prev;
            ext_prev <= next_ext_prev;
        end
    end

    // ==========================================================
    // source selection
    logic [5:0] src;
    logic [5:0] halt;
    logic [5:0] next_count_pulse;
    logic d2;
    logic d16;
    logic d4096;

    always_comb begin
        d2 = tick[TAP_DIV2];
        d16 = tick[TAP_DIV16];
        d4096 = tick[TAP_DIV4096];
        src[0] = !mode_first[F_T1_PRI] ? d16 :
                 (mode_first[F_T1_SEC] ? ext_edge : d4096);
        src[1] = mode_first[F_T2_PRI] ? ext_edge :
                 (mode_first[F_T2_SEC] ? timer_overflow[0] : d16);
        src[2] = mode_second[F_T3_SRC] ?
                 (sys_ctrl[F_T3_AUX] ? ext_edge : d4096) : d16;
        unique case ({mode_second[F_T4_HIGH], mode_second[F_T4_LOW]})
            T4_T3_OVF: src[3] = timer_overflow[2];
            T4_DIV16: src[3] = d16;
            T4_DIV2: src[3] = d2;
            T4_SUB_RAW: src[3] = sub_edge;
        endcase
        src[4] = !mode_second[F_T5_PRI] ? d16 :
                 (mode_first[F_T5_ALT] ? timer_overflow[3] :
                  timer_overflow[1]);
        src[5] = mode_first[F_T6_INT] ? timer_overflow[4] : d16;
        halt = {mode_second[F_T6_HALT], mode_second[F_T5_HALT],
                mode_second[F_T4_HALT], mode_second[F_T3_HALT],
                mode_first[F_T2_HALT], mode_first[F_T1_HALT]};
        next_count_pulse = src & ~halt;
        status_word = {20'h00000, 2'b00, halt, 3'b000, sys_edge};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_pulse <= 6'h00;
            timer_halted <= 6'h00;
        end else begin
            count_pulse <= next_count_pulse;
            timer_halted <= halt;
        end
    end
endmodule

// File: pkg/timer_src_pkg.sv
// Purpose: constants for timer count source and stop control
// Assumes: AXI4-Lite byte addressing, one 32-bit word per register
// Notes: mode register fields are bit positions within 8-bit registers
package timer_src_pkg;
    // ==========================================================
    // register map
    localparam logic [11:0] ADDR_MODE_FIRST = 12'h0F4;
    localparam logic [11:0] ADDR_MODE_SECOND = 12'h0F5;
    localparam int MODE_FIRST_INDEX = 32'h0F4;
    localparam int MODE_SECOND_INDEX = 32'h0F5;
    localparam logic [11:0] ADDR_MODE_FIRST_BYTE = 12'h3D0;
    localparam logic [11:0] ADDR_MODE_SECOND_BYTE = 12'h3D4;
    localparam logic [11:0] ADDR_SYS_CTRL = 12'h400;
    localparam logic [11:0] ADDR_STATUS = 12'h404;
    localparam int ADDR_W = 12;
    localparam logic [7:0] MODE_FIRST_RESET = 8'h00;
    localparam logic [7:0] MODE_SECOND_RESET = 8'h00;
    localparam logic [1:0] SYS_CTRL_RESET = 2'h0;
    // ==========================================================
    // first mode register fields
    localparam int F_T1_PRI = 0;
    localparam int F_T2_PRI = 1;
    localparam int F_T1_HALT = 2;
    localparam int F_T2_HALT = 3;
    localparam int F_T2_SEC = 4;
    localparam int F_T1_SEC = 5;
    localparam int F_T5_ALT = 6;
    localparam int F_T6_INT = 7;
    // second mode register fields
    localparam int F_T3_SRC = 0;
    localparam int F_T4_LOW = 1;
    localparam int F_T3_HALT = 2;
    localparam int F_T4_HALT = 3;
    localparam int F_T4_HIGH = 4;
    localparam int F_T5_HALT = 5;
    localparam int F_T6_HALT = 6;
    localparam int F_T5_PRI = 7;
    // own control register: system clock select, third timer aux bit
    localparam int F_SYS_SUB = 0;
    localparam int F_T3_AUX = 1;
    // ==========================================================
    // prescaler taps
    localparam int DIV_W = 12;
    localparam int TAP_DIV2 = 0;
    localparam int TAP_DIV16 = 3;
    localparam int TAP_DIV4096 = 11;
    // fourth timer source codes {high,low}
    localparam logic [1:0] T4_T3_OVF = 2'h0;
    localparam logic [1:0] T4_DIV16 = 2'h1;
    localparam logic [1:0] T4_DIV2 = 2'h2;
    localparam logic [1:0] T4_SUB_RAW = 2'h3;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: hw/osc_prescaler.sv
// Purpose: divides the selected system oscillator into tick pulses
// Assumes: oscillator edges arrive as a synchronised level
// Notes: tick for tap n is one aclk wide every 2^(n+1) oscillator edges
`timescale 1ns/100ps
module osc_prescaler
    import timer_src_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic osc_level,
    output logic osc_edge,
    output logic [DIV_W-1:0] tick
);
    logic prev;
    logic [DIV_W-1:0] count;
    logic next_prev;
    logic [DIV_W-1:0] next_count;
    logic [DIV_W-1:0] next_tick;

    always_comb begin
        next_prev = osc_level;
        osc_edge = osc_level & ~prev;
        next_count = count;
        next_tick = '0;
        if (osc_edge) begin
            next_count = count + 1'b1;
            // a tap fires when all lower bits and itself roll over
            next_tick[0] = count[0];
            for (int i = 1; i < DIV_W; i++) begin
                next_tick[i] = next_tick[i-1] & count[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev <= 1'b0;
            count <= '0;
            tick <= '0;
        end else begin
            prev <= next_prev;
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule

// File: tb/timer_src_sva.sv
// Purpose: port-level checks for timer source and halt control
// Assumes: one clock domain, synchronous active-low reset
// Notes: register contents are not visible, so checks stay at the ports
`timescale 1ns/100ps
module timer_src_sva
    import timer_src_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [5:0] count_pulse,
    input wire logic [5:0] timer_halted
);
    // ==========================================================
    // sequences
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence b_waiting;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    sequence r_waiting;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    // ==========================================================
    // assertions
    AST_WR_ANSWER: assert property (aw_w_taken |=> s_axi_bvalid)
        else $error("write response missing");
    AST_RD_ANSWER: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read data missing");
    AST_B_STANDS: assert property (b_waiting |=> s_axi_bvalid)
        else $error("write response dropped early");
    AST_R_STANDS: assert property
        (r_waiting |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed");
    AST_W_REFUSED: assert property
        (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    AST_AR_REFUSED: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    AST_UPPER_ZERO: assert property
        (s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h0)
        else $error("upper read bits not zero");
    AST_HALT_GATE: assert property (
        (count_pulse & timer_halted & $past(timer_halted)) == 6'h00)
        else $error("halted timer received a count");
endmodule

bind timer_source_and_stop_control timer_src_sva u_timer_src_sva (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .count_pulse(count_pulse),
    .timer_halted(timer_halted)
);

// File: tb/test_timer_source_and_stop_control.sv
// Purpose: directed bench for timer source and halt control
// Assumes: oscillators held still except in the prescaler test
// Notes: count pulses are tallied per timer and compared as deltas
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module test_timer_source_and_stop_control
    import timer_src_pkg::*;
;
    logic aclk = 0;
    logic aresetn = 0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic main_osc = 0, sub_osc = 0, external_count_pin = 0;
    logic [5:0] timer_overflow = 6'h00;
    logic [5:0] count_pulse, timer_halted;
    integer pulse_cnt [6] = '{default: 0};
    integer base [6];
    int fails = 0;
    int check_count = 0;

    always #12.5 aclk = ~aclk;

    always @(posedge aclk) begin
        for (int i = 0; i < 6; i++) begin
            pulse_cnt[i] <= pulse_cnt[i] + count_pulse[i];
        end
    end

    timer_source_and_stop_control u_timer_source_and_stop_control (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .main_osc(main_osc),
        .sub_osc(sub_osc), .external_count_pin(external_count_pin),
        .timer_overflow(timer_overflow), .count_pulse(count_pulse),
        .timer_halted(timer_halted)
    );

    // ==========================================================
    // bus and helper tasks
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, RESP_OKAY)
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e,
                      input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, {24'h0, e})
        `CHK(s_axi_rresp, r)
    endtask

    task automatic snap;
        @(negedge aclk);
        base = pulse_cnt;
    endtask

    task automatic chk_cnt(input int i, input integer e);
        @(negedge aclk);
        `CHK(pulse_cnt[i] - base[i], e)
    endtask

    task automatic ovf(input int src, input int dst, input integer e);
        snap;
        @(posedge aclk);
        timer_overflow <= 6'(1 << src);
        @(posedge aclk);
        timer_overflow <= 6'h00;
        repeat (4) @(posedge aclk);
        chk_cnt(dst, e);
    endtask

    // rising edges every four aclk cycles, slow enough to synchronise
    task automatic osc_run(input logic use_sub, input int edges);
        repeat (edges) begin
            @(posedge aclk);
            if (use_sub) sub_osc <= 1'b1;
            else main_osc <= 1'b1;
            repeat (2) @(posedge aclk);
            main_osc <= 1'b0;
            sub_osc <= 1'b0;
            @(posedge aclk);
        end
        repeat (10) @(posedge aclk);
    endtask

    task automatic pin_pulse;
        snap;
        @(posedge aclk);
        external_count_pin <= 1'b1;
        repeat (6) @(posedge aclk);
        external_count_pin <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        rd(ADDR_MODE_FIRST_BYTE, MODE_FIRST_RESET, RESP_OKAY);
        rd(ADDR_MODE_SECOND_BYTE, MODE_SECOND_RESET, RESP_OKAY);
        rd(12'h800, 8'h00, RESP_SLVERR);
    endtask

    task automatic t_osc;
        wr(ADDR_MODE_SECOND_BYTE, 8'h10);
        snap;
        osc_run(1'b0, 32);
        chk_cnt(0, 2);
        chk_cnt(3, 16);
        chk_cnt(4, 2);
        chk_cnt(5, 2);
        wr(ADDR_SYS_CTRL, 8'h01);
        wr(ADDR_MODE_SECOND_BYTE, 8'h12);
        snap;
        osc_run(1'b1, 32);
        chk_cnt(0, 2);
        chk_cnt(3, 32);
        wr(ADDR_SYS_CTRL, 8'h00);
        // one full /4096 period gives one tick whatever the phase
        wr(ADDR_MODE_FIRST_BYTE, 8'h01);
        wr(ADDR_MODE_SECOND_BYTE, 8'h03);
        snap;
        osc_run(1'b0, 4096);
        chk_cnt(0, 1);
        chk_cnt(1, 256);
        chk_cnt(2, 1);
        chk_cnt(3, 256);
        wr(ADDR_MODE_FIRST_BYTE, 8'h00);
        wr(ADDR_MODE_SECOND_BYTE, 8'h00);
    endtask

    task automatic t_halt;
        wr(ADDR_MODE_FIRST_BYTE, 8'h0C);
        wr(ADDR_MODE_SECOND_BYTE, 8'h6C);
        @(posedge aclk);
        @(negedge aclk);
        `CHK(timer_halted, 6'h3F)
        rd(ADDR_MODE_SECOND_BYTE, 8'h6C, RESP_OKAY);
        wr(ADDR_MODE_FIRST_BYTE, 8'h00);
        wr(ADDR_MODE_SECOND_BYTE, 8'h00);
    endtask

    task automatic t_cascade;
        wr(ADDR_MODE_FIRST_BYTE, 8'h90);
        wr(ADDR_MODE_SECOND_BYTE, 8'h80);
        ovf(0, 1, 1);
        ovf(1, 4, 1);
        ovf(2, 3, 1);
        ovf(4, 5, 1);
        wr(ADDR_MODE_FIRST_BYTE, 8'hD0);
        ovf(3, 4, 1);
        ovf(1, 4, 0);
        wr(ADDR_MODE_FIRST_BYTE, 8'h00);
        ovf(0, 1, 0);
        wr(ADDR_MODE_SECOND_BYTE, 8'h00);
    endtask

    task automatic t_pin;
        wr(ADDR_MODE_FIRST_BYTE, 8'h23);
        wr(ADDR_MODE_SECOND_BYTE, 8'h01);
        wr(ADDR_SYS_CTRL, 8'h02);
        pin_pulse;
        chk_cnt(0, 1);
        chk_cnt(1, 1);
        chk_cnt(2, 1);
        wr(ADDR_MODE_FIRST_BYTE, 8'h27);
        pin_pulse;
        chk_cnt(0, 0);
        chk_cnt(1, 1);
        wr(ADDR_MODE_FIRST_BYTE, 8'h03);
        pin_pulse;
        chk_cnt(0, 0);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge aclk);
        fails++;
        end_of_test;
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_osc;
        t_halt;
        t_cascade;
        t_pin;
        end_of_test;
    end
endmodule
